// *** include/frs_pkg.sv ***
package frs_pkg;
    localparam int CLK_MHZ     = 50;
    // self-timed durations, longest figures
    localparam int T_SE_MS     = 300;
    localparam int T_PP_US     = 2400;
    localparam int T_RESUME_NS = 200;
    localparam int ERASE_CYC   = T_SE_MS * 1000 * CLK_MHZ;
    localparam int PROG_CYC    = T_PP_US * CLK_MHZ;
    localparam int RESUME_CYC  = (T_RESUME_NS * CLK_MHZ) / 1000;

    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SEC_ERASE    = 8'h44;
    localparam logic [7:0] OP_SEC_PROG     = 8'h42;
    localparam logic [7:0] OP_SEC_READ     = 8'h48;
    localparam logic [7:0] OP_RESUME       = 8'h7A;
    localparam logic [7:0] OP_SUSPEND      = 8'h75;

    localparam int         BITS_W        = 12;
    localparam logic [11:0] BITS_MAX     = 12'hFFF;
    localparam logic [11:0] CMD_BITS     = 12'h008;
    localparam logic [11:0] OPC_LAST     = 12'h007;
    localparam logic [11:0] ADDR_LAST    = 12'h01F;
    localparam logic [11:0] DATA_START   = 12'h020;
    localparam logic [11:0] READ_START   = 12'h028;
    localparam logic [11:0] PROG_MAX     = 12'h820;
    localparam logic [2:0]  BYTE_LAST    = 3'h7;
    localparam logic [2:0]  BYTE_FIRST   = 3'h0;
    localparam logic [7:0]  DATA_IDX_OFS = 8'h04;

    localparam int         AREA_BYTES  = 256;
    localparam int         MEM_BYTES   = 1024;
    localparam int         TIMER_W     = 24;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;

    typedef struct packed {
        logic [7:0]        opcode;
        logic [23:0]       addr;
        logic [BITS_W-1:0] bits;
    } frs_frame_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PROG  = 2'b01,
        ST_ERASE = 2'b10
    } frs_state_t;
endpackage

// *** rtl/frs_security_core.sv ***
// Contract
// - Resume taken only when suspended is set and busy is clear.
// - Accepted resume clears suspended now, busy returns within 200 ns.
// - Four separate 256-byte security areas, programmed apart; security erase clears all four.
// - Security erase or program needs the write enable latch set.
// - Security erase runs only if chip select rises after exactly eight bits.
// - Security erase is self-timed like sector erase; busy set, latch cleared.
// - Lock flag set means security erase and program are ignored until reset.
// - Program frame: opcode, three address bytes, one to 256 data bytes.
// - Security program self-timed like page program; busy set, latch cleared.
// - Read frame: opcode, three address bytes, dummy byte, sampled on rise.
// - Read data shifted out on falling edge; address advances per byte.
// - Low ten read address bits wrap to zero past the last byte.
// - Read may start anywhere and lasts until chip select rises; here only 507 data bytes, then zeros once the bit count saturates.
// - Delivered state: bytes read all ones, status flags zero.
// - Suspend taken only when not suspended and busy with a main operation.
`timescale 1ns/1ps
`default_nettype none

module frs_security_core
    import frs_pkg::*;
#(
    parameter logic [TIMER_W-1:0] ERASE_CYCLES = TIMER_W'(ERASE_CYC),
    parameter logic [TIMER_W-1:0] PROG_CYCLES  = TIMER_W'(PROG_CYC)
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic mainBusy,
    input  wire logic lockSetReq,
    input  wire logic linkSclk,
    input  wire logic csN,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdoEn,
    output logic      busyFlag,
    output logic      writeEnableLatch,
    output logic      suspendedFlag,
    output logic      securityLockFlag
);

////////////////////////////////////////////////////////////////////////////////
// link side, rising edge of the serial clock

    logic              linkRst;
    logic [BITS_W-1:0] bitCnt_q, bitCnt_d;
    logic [7:0]        shIn_q, shIn_d;
    frs_frame_t        frame_q, frame_d;
    logic [9:0]        rdAddr_q, rdAddr_d;
    logic [255:0]      mask_q, mask_d;
    logic              busySync1_q, busySync2_q;
    logic [7:0]        rxByte;
    logic [7:0]        dataOfs;
    logic              byteDone;
    logic              progWr;
    logic [7:0]        pageBuf [AREA_BYTES];
    logic [7:0]        secMem [MEM_BYTES];

    assign linkRst  = rst | csN;
    assign rxByte   = {shIn_q[6:0], sdi};
    assign byteDone = (bitCnt_q[2:0] == BYTE_LAST);
    assign dataOfs  = frame_q.addr[7:0] + (bitCnt_q[10:3] - DATA_IDX_OFS);
    assign progWr   = (frame_q.opcode == OP_SEC_PROG) && (bitCnt_q >= DATA_START) && byteDone;

    always_comb begin
        bitCnt_d = (bitCnt_q == BITS_MAX) ? bitCnt_q : bitCnt_q + 12'h001;
        shIn_d   = rxByte;
        frame_d  = frame_q;
        rdAddr_d = rdAddr_q;
        mask_d   = (bitCnt_q == '0) ? '0 : mask_q;
        frame_d.bits = bitCnt_d;
        if (bitCnt_q == OPC_LAST) begin
            frame_d.opcode = rxByte;
        end
        if ((bitCnt_q >= CMD_BITS) && (bitCnt_q <= ADDR_LAST)) begin
            frame_d.addr = {frame_q.addr[22:0], sdi};
        end
        if (bitCnt_q == ADDR_LAST) begin
            rdAddr_d = {frame_q.addr[8:0], sdi};
        end else if ((bitCnt_q >= READ_START) && byteDone) begin
            rdAddr_d = rdAddr_q + 10'h001;
        end
        if (progWr) begin
            mask_d[dataOfs] = 1'b1;
        end
    end

    always_ff @(posedge linkSclk or posedge linkRst) begin
        if (linkRst) begin
            bitCnt_q <= '0;
        end else begin
            bitCnt_q <= bitCnt_d;
        end
    end

    always_ff @(posedge linkSclk or posedge rst) begin
        if (rst) begin
            shIn_q      <= '0;
            frame_q     <= '0;
            rdAddr_q    <= '0;
            mask_q      <= '0;
            busySync1_q <= 1'b0;
            busySync2_q <= 1'b0;
        end else begin
            shIn_q      <= shIn_d;
            frame_q     <= frame_d;
            rdAddr_q    <= rdAddr_d;
            mask_q      <= mask_d;
            busySync1_q <= busyFlag;
            busySync2_q <= busySync1_q;
        end
    end

    // page buffer wraps within 256 bytes, later bytes overwrite
    always_ff @(posedge linkSclk) begin
        if (progWr) begin
            pageBuf[dataOfs] <= rxByte;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// link side, falling edge: read data out

    logic [7:0] outSh_q, outSh_d;
    logic       sdo_d, sdoEn_d;
    logic       readOk;
    logic [7:0] rdData;

    // array only changes at frame end, so it is quiet while shifting
    assign rdData = secMem[rdAddr_q];
    assign readOk = (frame_q.opcode == OP_SEC_READ) && (bitCnt_q >= READ_START)
                    && (frame_q.addr[23:10] == ADDR_HI_ZERO) && !busySync2_q;

    always_comb begin
        outSh_d = {outSh_q[6:0], 1'b0};
        sdo_d   = outSh_q[7];
        sdoEn_d = readOk;
        if (readOk && (bitCnt_q[2:0] == BYTE_FIRST)) begin
            outSh_d = {rdData[6:0], 1'b0};
            sdo_d   = rdData[7];
        end
        if (!readOk) begin
            sdo_d = 1'b0;
        end
    end

    always_ff @(negedge linkSclk or posedge linkRst) begin
        if (linkRst) begin
            outSh_q <= '0;
            sdo     <= 1'b0;
            sdoEn   <= 1'b0;
        end else begin
            outSh_q <= outSh_d;
            sdo     <= sdo_d;
            sdoEn   <= sdoEn_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// system side: frame end decode and self-timed operations

    logic               csSync1_q, csSync2_q, csSync3_q;
    logic               csRise;
    frs_state_t         state_q, state_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic               wel_d, susp_d, lock_d, busy_d;
    logic               opAllowed, startErase, startProg;
    logic               exactCmd, progLenOk;

    assign csRise    = csSync2_q & ~csSync3_q;
    assign exactCmd  = (frame_q.bits == CMD_BITS);
    assign progLenOk = (frame_q.bits >= READ_START) && (frame_q.bits <= PROG_MAX)
                       && (frame_q.bits[2:0] == BYTE_FIRST);
    assign opAllowed = csRise && writeEnableLatch && !securityLockFlag
                       && !busyFlag && !suspendedFlag;
    assign startErase = opAllowed && (frame_q.opcode == OP_SEC_ERASE) && exactCmd;
    assign startProg  = opAllowed && (frame_q.opcode == OP_SEC_PROG) && progLenOk
                        && (frame_q.addr[23:10] == ADDR_HI_ZERO);

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        wel_d   = writeEnableLatch;
        susp_d  = suspendedFlag;
        lock_d  = securityLockFlag | lockSetReq;
        if (csRise && exactCmd && (frame_q.opcode == OP_WRITE_ENABLE) && !busyFlag) begin
            wel_d = 1'b1;
        end
        if (csRise && exactCmd && (frame_q.opcode == OP_RESUME)
            && suspendedFlag && !busyFlag) begin
            susp_d = 1'b0;
        end
        if (csRise && exactCmd && (frame_q.opcode == OP_SUSPEND)
            && !suspendedFlag && busyFlag && mainBusy && (state_q == ST_IDLE)) begin
            susp_d = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (startErase) begin
                    state_d = ST_ERASE;
                    timer_d = ERASE_CYCLES - 24'h000001;
                    wel_d   = 1'b0;
                end else if (startProg) begin
                    state_d = ST_PROG;
                    timer_d = PROG_CYCLES - 24'h000001;
                    wel_d   = 1'b0;
                end
            end
            ST_PROG, ST_ERASE: begin
                if (timer_q == '0) begin
                    state_d = ST_IDLE;
                end else begin
                    timer_d = timer_q - 24'h000001;
                end
            end
            default: begin
                state_d = ST_IDLE;
                timer_d = '0;
            end
        endcase
        // busy returns on the same edge that clears suspended, well inside RESUME_CYC
        busy_d = (state_d != ST_IDLE) | (mainBusy & ~susp_d);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csSync1_q        <= 1'b1;
            csSync2_q        <= 1'b1;
            csSync3_q        <= 1'b1;
            state_q          <= ST_IDLE;
            timer_q          <= '0;
            writeEnableLatch <= 1'b0;
            suspendedFlag    <= 1'b0;
            securityLockFlag <= 1'b0;
            busyFlag         <= 1'b0;
        end else begin
            csSync1_q        <= csN;
            csSync2_q        <= csSync1_q;
            csSync3_q        <= csSync2_q;
            state_q          <= state_d;
            timer_q          <= timer_d;
            writeEnableLatch <= wel_d;
            suspendedFlag    <= susp_d;
            securityLockFlag <= lock_d;
            busyFlag         <= busy_d;
        end
    end

    // array committed at frame end; the buffer is still while chip select is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                secMem[i] <= ERASED_BYTE;
            end
        end else if (startErase) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                secMem[i] <= ERASED_BYTE;
            end
        end else if (startProg) begin
            for (int i = 0; i < AREA_BYTES; i++) begin
                if (mask_q[i]) begin
                    secMem[{frame_q.addr[9:8], 8'(i)}] <=
                        secMem[{frame_q.addr[9:8], 8'(i)}] & pageBuf[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** dv/frs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module frs_host_model (
    output logic      linkSclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdo
);
    logic [2047:0] rx;
    initial begin
        linkSclk = 1'b0;
        csN      = 1'b1;
        sdi      = 1'b0;
    end
    // clock stands low between frames, released line toggles
    task automatic xfer(input logic [2119:0] tx, input int n, input int nr);
        csN = 1'b0;
        #37;
        for (int i = 0; i < n + nr; i++) begin
            sdi = (i < n) ? tx[2119 - i] : ~sdi;
            #80 linkSclk = 1'b1;
            if (i >= n) rx = {rx[2046:0], sdo};
            #80 linkSclk = 1'b0;
        end
        #40 csN = 1'b1;
        sdi = ~sdi;
        #100;
    endtask
endmodule
`default_nettype wire

// *** dv/frs_security_core_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module frs_security_core_chk
    import frs_pkg::*;
#(
    parameter logic [TIMER_W-1:0] ERASE_CYCLES = TIMER_W'(ERASE_CYC),
    parameter logic [TIMER_W-1:0] PROG_CYCLES  = TIMER_W'(PROG_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mainBusy,
    input wire logic lockSetReq,
    input wire logic linkSclk,
    input wire logic csN,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdoEn,
    input wire logic busyFlag,
    input wire logic writeEnableLatch,
    input wire logic suspendedFlag,
    input wire logic securityLockFlag
);
    logic [TIMER_W-1:0] runQ;
    logic [TIMER_W-1:0] runD;
    logic [7:0]         bitQ;
    logic [7:0]         bitD;
    logic [39:0]        shQ;
    logic [39:0]        shD;
    always_comb runD = busyFlag ? runQ + 1'b1 : '0;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) runQ <= '0;
        else runQ <= runD;
    end
    always_comb begin
        bitD = (bitQ == 8'hFF) ? bitQ : bitQ + 8'h01;
        shD  = {shQ[38:0], sdi};
    end
    always_ff @(posedge linkSclk or posedge csN or posedge rst) begin
        if (rst || csN) begin
            bitQ <= '0;
            shQ  <= '0;
        end else begin
            bitQ <= bitD;
            shQ  <= shD;
        end
    end
    localparam int RESUME_MAX = RESUME_CYC;
    ////////////////////////////////////////
    sequence s_secStart;
        $rose(busyFlag) && !mainBusy && !$past(mainBusy);
    endsequence
    property p_lock_hold;
        @(posedge clk_sys) disable iff (rst) securityLockFlag |=> securityLockFlag;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    property p_lock_set;
        @(posedge clk_sys) disable iff (rst) lockSetReq |=> securityLockFlag;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_ops;
        @(posedge clk_sys) disable iff (rst) s_secStart |-> !$past(securityLockFlag);
    endproperty
    a_lock_ops: assert property (p_lock_ops) else $error("op while locked");
    property p_wel_set;
        @(posedge clk_sys) disable iff (rst)
            s_secStart |-> $past(writeEnableLatch) || $past(writeEnableLatch, 2);
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("op without latch");
    property p_wel_clr;
        @(posedge clk_sys) disable iff (rst) s_secStart |-> !writeEnableLatch;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept");
    property p_busy_len;
        @(posedge clk_sys) disable iff (rst)
            $fell(busyFlag) && !mainBusy && !$past(mainBusy) && !$past(mainBusy, 2)
            |-> runQ inside {[PROG_CYCLES - 1 : PROG_CYCLES + 1],
                             [ERASE_CYCLES - 1 : ERASE_CYCLES + 1]};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_sus_entry;
        @(posedge clk_sys) disable iff (rst)
            $rose(suspendedFlag) |-> $past(busyFlag) && mainBusy;
    endproperty
    a_sus_entry: assert property (p_sus_entry) else $error("bad suspend");
    property p_resume;
        @(posedge clk_sys) disable iff (rst)
            $fell(suspendedFlag) |-> !$past(busyFlag) ##[0:RESUME_MAX] busyFlag;
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume");
    property p_rd_on;
        @(posedge linkSclk) disable iff (rst || csN)
            bitQ == 8'h28 && shQ[39:32] == OP_SEC_READ && shQ[31:18] == 14'h0000
            && !busyFlag |-> sdoEn;
    endproperty
    a_rd_on: assert property (p_rd_on) else $error("read not driven");
    // deselect drops the read drive at once
    property p_rd_off;
        @(posedge clk_sys) disable iff (rst) csN |-> !sdoEn && !sdo;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("read drive left on");
endmodule
bind frs_security_core frs_security_core_chk #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES (PROG_CYCLES)
) u_chk (
    .clk_sys(clk_sys), .rst(rst), .mainBusy(mainBusy), .lockSetReq(lockSetReq),
    .linkSclk(linkSclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
    .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch),
    .suspendedFlag(suspendedFlag), .securityLockFlag(securityLockFlag)
);
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import frs_pkg::*;;
    localparam int PROG_N  = 10;
    localparam int ERASE_N = 20;
    localparam int PUW_NS  = 1000;
    logic          clk_sys, rst, mainBusy, lockSetReq, linkSclk, csN, sdi, sdo, sdoEn;
    logic          busyFlag, writeEnableLatch, suspendedFlag, securityLockFlag;
    logic [7:0]    mem [0:1023];
    logic [2119:0] tx;
    logic [9:0]    a;
    int            n;
    int            n_mismatch = 0;
    int            total_checks = 0;
    frs_security_core #(
        .ERASE_CYCLES(TIMER_W'(ERASE_N)),
        .PROG_CYCLES (TIMER_W'(PROG_N))
    ) u_dut (
        .clk_sys(clk_sys), .rst(rst), .mainBusy(mainBusy), .lockSetReq(lockSetReq),
        .linkSclk(linkSclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
        .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch),
        .suspendedFlag(suspendedFlag), .securityLockFlag(securityLockFlag)
    );
    frs_host_model u_host (.linkSclk(linkSclk), .csN(csN), .sdi(sdi), .sdo(sdo));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // program byte k lands in the same area, offset wrapping at 256
    function automatic logic [9:0] prog_addr(input logic [9:0] ad, input int k);
        return {ad[9:8], 8'(ad[7:0] + k)};
    endfunction
    // read address wraps over all four areas
    function automatic logic [9:0] rd_addr(input logic [9:0] ad, input int k);
        return 10'(ad + k);
    endfunction
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        int k;
        for (k = 0; k < 200 && busyFlag !== v; k++) @(posedge clk_sys);
        if (k == 200) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, busyFlag, v);
            final_report();
        end
        #1;
    endtask
    // a wrongly started operation would show busy somewhere in this span
    task automatic quiet();
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            chk(busyFlag, 0);
        end
    endtask
    task automatic op_ok();
        wait_busy(1'b1);
        chk(writeEnableLatch, 0);
        wait_busy(1'b0);
    endtask
    task automatic cmd(input logic [7:0] op, input int nb);
        tx = '0;
        tx[2119 -: 8] = op;
        u_host.xfer(tx, nb, 0);
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    // expected array follows only accepted programs, which clear bits only
    task automatic prog(input logic [9:0] ad, input int nd, input logic ok);
        logic [7:0] d;
        tx = '0;
        tx[2119 -: 32] = {OP_SEC_PROG, 14'h0000, ad};
        for (int k = 0; k < nd; k++) begin
            d = 8'($urandom);
            tx[2087 - 8 * k -: 8] = d;
            if (ok) mem[prog_addr(ad, k)] &= d;
        end
        u_host.xfer(tx, 32 + 8 * nd, 0);
    endtask
    task automatic rd(input logic [9:0] ad, input int nd);
        tx = '0;
        tx[2119 -: 32] = {OP_SEC_READ, 14'h0000, ad};
        u_host.xfer(tx, 40, 8 * nd);
        for (int k = 0; k < nd; k++)
            chk(u_host.rx[8 * (nd - 1 - k) +: 8], mem[rd_addr(ad, k)]);
    endtask
    ////////////////////////////////////////
    initial begin
        #1900000;
        n_mismatch++;
        final_report();
    end
    initial begin
        rst        = 1'b1;
        mainBusy   = 1'b0;
        lockSetReq = 1'b0;
        for (int i = 0; i < 1024; i++) mem[i] = ERASED_BYTE;
        void'($urandom(32'hD0D40D5B));
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({busyFlag, writeEnableLatch, suspendedFlag, securityLockFlag}, 0);
        rd(10'h3FE, 4);
        // scaled down: this model has no write inhibit window
        #(PUW_NS);
        $display("test reset done");
        prog(10'h005, 2, 1'b0);
        quiet();
        cmd(OP_WRITE_ENABLE, 8);
        tx = '0;
        tx[2119 -: 40] = {OP_SEC_PROG, 24'h010005, 8'h00};
        u_host.xfer(tx, 40, 0);
        quiet();
        chk(writeEnableLatch, 1);
        rd(10'h005, 1);
        for (int t = 0; t < 4; t++) begin
            a = 10'($urandom);
            n = (t == 0) ? 256 : (t == 1) ? 1 : int'($urandom_range(255, 2));
            cmd(OP_WRITE_ENABLE, 8);
            chk(writeEnableLatch, 1);
            prog(a, n, 1'b1);
            op_ok();
            rd(a - 10'h001, 3);
        end
        $display("test program done");
        cmd(OP_WRITE_ENABLE, 8);
        cmd(OP_SEC_ERASE, 16);
        quiet();
        chk(writeEnableLatch, 1);
        cmd(OP_SEC_ERASE, 8);
        op_ok();
        for (int i = 0; i < 1024; i++) mem[i] = ERASED_BYTE;
        rd(a, 4);
        $display("test erase done");
        mainBusy = 1'b1;
        cmd(OP_RESUME, 8);
        chk({suspendedFlag, busyFlag}, 2'b01);
        for (int t = 0; t < 2; t++) begin
            cmd(OP_SUSPEND, 8);
            chk({suspendedFlag, busyFlag}, 2'b10);
        end
        cmd(OP_RESUME, 8);
        chk({suspendedFlag, busyFlag}, 2'b01);
        mainBusy = 1'b0;
        $display("test suspend done");
        lockSetReq = 1'b1;
        @(posedge clk_sys);
        #1 lockSetReq = 1'b0;
        cmd(OP_WRITE_ENABLE, 8);
        chk(securityLockFlag, 1);
        cmd(OP_SEC_ERASE, 8);
        quiet();
        prog(a, 3, 1'b0);
        quiet();
        rd(a, 3);
        $display("test lock done");
        @(posedge clk_sys);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({busyFlag, writeEnableLatch, suspendedFlag, securityLockFlag}, 0);
        rd(a, 2);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
